// *** hw/dbg_gpio_top.sv ***
// Dual byte-wide port data registers with pin mode control on APB
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module dbg_gpio_top #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WIDTH-1:0] first_port_pin_in,
  output logic [WIDTH-1:0] first_port_pin_out,
  output logic [WIDTH-1:0] first_port_pin_oe,
  output logic [WIDTH-1:0] first_port_pullup_en,
  input wire logic [WIDTH-1:0] second_port_pin_in,
  output logic [WIDTH-1:0] second_port_pin_out,
  output logic [WIDTH-1:0] second_port_pin_oe,
  output logic [WIDTH-1:0] second_port_pullup_en
);

  // -------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------
  // Bus slave state
  dbg_pkg::dbg_bus_state_t state_reg;
  dbg_pkg::dbg_bus_state_t state_next;

  // Port data, one bit per pin
  logic [WIDTH-1:0] first_port_data_reg;
  logic [WIDTH-1:0] first_port_data_next;
  logic [WIDTH-1:0] second_port_data_reg;
  logic [WIDTH-1:0] second_port_data_next;

  // Pin function modes, two bits per pin
  logic [2*WIDTH-1:0] first_port_mode_reg;
  logic [2*WIDTH-1:0] first_port_mode_next;
  logic [2*WIDTH-1:0] second_port_mode_reg;
  logic [2*WIDTH-1:0] second_port_mode_next;

  // Registered bus response
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  // Pin drive and pull-up enables
  logic [WIDTH-1:0] first_oe_reg;
  logic [WIDTH-1:0] first_oe_next;
  logic [WIDTH-1:0] second_oe_reg;
  logic [WIDTH-1:0] second_oe_next;
  logic [WIDTH-1:0] first_pull_reg;
  logic [WIDTH-1:0] first_pull_next;
  logic [WIDTH-1:0] second_pull_reg;
  logic [WIDTH-1:0] second_pull_next;

  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  // Decode results, all but wr_commit taken straight from paddr; wr_commit also needs the bus state
  logic [dbg_pkg::IDX_DECODE_BITS-1:0] acc_idx;
  logic hit_first_data;
  logic hit_second_data;
  logic hit_first_mode;
  logic hit_second_mode;
  logic hit_any;
  logic wr_commit;

  // Index is the byte address over four; region bits are dropped
  assign acc_idx = paddr[dbg_pkg::IDX_DECODE_BITS+1:2];

  // Translated and untranslated views reach the same register
  assign hit_first_data =
    (acc_idx == dbg_pkg::FIRST_DATA_IDX[dbg_pkg::IDX_DECODE_BITS-1:0]) ||
    (acc_idx == dbg_pkg::FIRST_DATA_ALIAS_IDX[dbg_pkg::IDX_DECODE_BITS-1:0]);
  assign hit_second_data =
    (acc_idx == dbg_pkg::SECOND_DATA_IDX[dbg_pkg::IDX_DECODE_BITS-1:0]);
  assign hit_first_mode =
    (acc_idx == dbg_pkg::FIRST_MODE_IDX[dbg_pkg::IDX_DECODE_BITS-1:0]);
  assign hit_second_mode =
    (acc_idx == dbg_pkg::SECOND_MODE_IDX[dbg_pkg::IDX_DECODE_BITS-1:0]);
  assign hit_any = hit_first_data | hit_second_data | hit_first_mode | hit_second_mode;

  // Write lands on the edge where the master sees pready high
  assign wr_commit = (state_reg == dbg_pkg::DBG_ST_ACK) & psel & penable & pwrite;

  // -------------------------------------------------------------
  // Write strobes
  // -------------------------------------------------------------
  logic wr_first_data;
  logic wr_second_data;
  logic [1:0] wr_first_mode;
  logic [1:0] wr_second_mode;

  // A clear byte lane leaves that part of the register alone
  assign wr_first_data = wr_commit & hit_first_data & pstrb[0];
  assign wr_second_data = wr_commit & hit_second_data & pstrb[0];

  // Mode registers take lanes 0 and 1, one lane per four pins
  assign wr_first_mode = {2{wr_commit & hit_first_mode}} & pstrb[1:0];
  assign wr_second_mode = {2{wr_commit & hit_second_mode}} & pstrb[1:0];

  // -------------------------------------------------------------
  // Pin input synchronisers
  // -------------------------------------------------------------
  dbg_sync_if #(.PINS(2*WIDTH)) sync_bus ();

  // Both ports share one synchroniser block
  assign sync_bus.raw = {second_port_pin_in, first_port_pin_in};

  dbg_pin_sync #(
    .PINS(2*WIDTH)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sync_bus)
  );

  logic [WIDTH-1:0] first_pin_sync;
  logic [WIDTH-1:0] second_pin_sync;

  // Low half is the first port, high half the second
  assign first_pin_sync = sync_bus.synced[WIDTH-1:0];
  assign second_pin_sync = sync_bus.synced[2*WIDTH-1:WIDTH];

  // -------------------------------------------------------------
  // Per-pin read view, drive and pull-up
  // -------------------------------------------------------------
  logic [WIDTH-1:0] first_read_view;
  logic [WIDTH-1:0] second_read_view;
  logic [WIDTH-1:0] first_next_is_out;
  logic [WIDTH-1:0] second_next_is_out;
  logic [WIDTH-1:0] first_next_is_pull;
  logic [WIDTH-1:0] second_next_is_pull;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      logic [1:0] first_mode;
      logic [1:0] second_mode;
      logic [1:0] first_mode_new;
      logic [1:0] second_mode_new;
      logic first_is_input;
      logic second_is_input;

      // Mode pair of this pin: high bit at 2n+1, low bit at 2n
      assign first_mode = first_port_mode_reg[2*b+1:2*b];
      assign second_mode = second_port_mode_reg[2*b+1:2*b];
      assign first_mode_new = first_port_mode_next[2*b+1:2*b];
      assign second_mode_new = second_port_mode_next[2*b+1:2*b];

      // High mode bit alone marks general input, pull-up or not
      assign first_is_input = first_mode[dbg_pkg::MODE_HI_OFS];
      assign second_is_input = second_mode[dbg_pkg::MODE_HI_OFS];

      // Input mode reads the pin, output and alternate read storage
      assign first_read_view[b] = first_is_input ?
        first_pin_sync[b] : first_port_data_reg[b];
      assign second_read_view[b] = second_is_input ?
        second_pin_sync[b] : second_port_data_reg[b];

      // Only general output drives; alternate and input leave the pin
      assign first_next_is_out[b] = (first_mode_new == dbg_pkg::MODE_OUT);
      assign second_next_is_out[b] = (second_mode_new == dbg_pkg::MODE_OUT);

      // Pull-up on only in input mode with low bit clear
      assign first_next_is_pull[b] = (first_mode_new == dbg_pkg::MODE_IN_PULL);
      assign second_next_is_pull[b] = (second_mode_new == dbg_pkg::MODE_IN_PULL);
    end
  endgenerate

  // -------------------------------------------------------------
  // Read data select
  // -------------------------------------------------------------
  logic [31:0] rd_word;

  // Data registers fill lane 0 only; bits above read as zero
  always_comb begin
    rd_word = dbg_pkg::READ_ZERO;
    if (hit_first_data) begin
      rd_word[WIDTH-1:0] = first_read_view;
    end else if (hit_second_data) begin
      rd_word[WIDTH-1:0] = second_read_view;
    end else if (hit_first_mode) begin
      rd_word[2*WIDTH-1:0] = first_port_mode_reg;
    end else if (hit_second_mode) begin
      rd_word[2*WIDTH-1:0] = second_port_mode_reg;
    end
  end

  // -------------------------------------------------------------
  // Bus handshake: one wait state, then pready for one cycle
  // -------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    case (state_reg)
      dbg_pkg::DBG_ST_IDLE: begin
        if (psel && penable) begin
          state_next = dbg_pkg::DBG_ST_ACK;
          pready_next = 1'b1;
          // Unmapped addresses answer with an error and zero data
          pslverr_next = ~hit_any;
          prdata_next = dbg_pkg::READ_ZERO;
          // Read word is caught here and holds until the next transfer
          if (!pwrite) begin
            prdata_next = rd_word;
          end
        end
      end
      dbg_pkg::DBG_ST_ACK: begin
        // Back to idle so the next transfer gets its own wait state
        state_next = dbg_pkg::DBG_ST_IDLE;
      end
      default: begin
        state_next = dbg_pkg::DBG_ST_IDLE;
      end
    endcase
  end

  // Bus response registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dbg_pkg::DBG_ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= dbg_pkg::READ_ZERO;
    end else begin
      state_reg <= state_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // -------------------------------------------------------------
  // Port data registers
  // -------------------------------------------------------------
  // Writes always store, whatever the mode; the mode only gates the pin
  always_comb begin
    first_port_data_next = first_port_data_reg;
    second_port_data_next = second_port_data_reg;
    if (wr_first_data) begin
      first_port_data_next = pwdata[WIDTH-1:0];
    end
    if (wr_second_data) begin
      second_port_data_next = pwdata[WIDTH-1:0];
    end
  end

  // Only power-on reset clears; there is no other reset path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_port_data_reg <= dbg_pkg::DATA_RESET;
      second_port_data_reg <= dbg_pkg::DATA_RESET;
    end else begin
      first_port_data_reg <= first_port_data_next;
      second_port_data_reg <= second_port_data_next;
    end
  end

  // -------------------------------------------------------------
  // Pin function mode registers
  // -------------------------------------------------------------
  // Lane by lane, so a one-byte write retunes only four pins
  always_comb begin
    first_port_mode_next = first_port_mode_reg;
    second_port_mode_next = second_port_mode_reg;
    if (wr_first_mode[0]) begin
      first_port_mode_next[7:0] = pwdata[7:0];
    end
    if (wr_first_mode[1]) begin
      first_port_mode_next[15:8] = pwdata[15:8];
    end
    if (wr_second_mode[0]) begin
      second_port_mode_next[7:0] = pwdata[7:0];
    end
    if (wr_second_mode[1]) begin
      second_port_mode_next[15:8] = pwdata[15:8];
    end
  end

  // Modes reset to alternate function: no pin driven, no pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_port_mode_reg <= dbg_pkg::MODE_RESET;
      second_port_mode_reg <= dbg_pkg::MODE_RESET;
    end else begin
      first_port_mode_reg <= first_port_mode_next;
      second_port_mode_reg <= second_port_mode_next;
    end
  end

  // -------------------------------------------------------------
  // Pin control registers
  // -------------------------------------------------------------
  // Enables follow the mode as it is written, not a cycle later
  always_comb begin
    first_oe_next = first_next_is_out;
    second_oe_next = second_next_is_out;
    first_pull_next = first_next_is_pull;
    second_pull_next = second_next_is_pull;
  end

  // Registered from the next mode so enable changes with the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_oe_reg <= '0;
      second_oe_reg <= '0;
      first_pull_reg <= '0;
      second_pull_reg <= '0;
    end else begin
      first_oe_reg <= first_oe_next;
      second_oe_reg <= second_oe_next;
      first_pull_reg <= first_pull_next;
      second_pull_reg <= second_pull_next;
    end
  end

  // -------------------------------------------------------------
  // Outputs, all straight from flops
  // -------------------------------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  // Data value always presented; enable decides whether it reaches the pin
  assign first_port_pin_out = first_port_data_reg;
  assign second_port_pin_out = second_port_data_reg;
  // Drive and pull-up enables, one flop per pin
  assign first_port_pin_oe = first_oe_reg;
  assign second_port_pin_oe = second_oe_reg;
  assign first_port_pullup_en = first_pull_reg;
  assign second_port_pullup_en = second_pull_reg;

endmodule : dbg_gpio_top

// *** hw/dbg_pkg.sv ***
// Constants shared by the dual byte-wide port data block
package dbg_pkg;

  // -------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // -------------------------------------------------------------
  localparam logic [31:0] FIRST_DATA_IDX = 32'h04000120;
  localparam logic [31:0] FIRST_DATA_ALIAS_IDX = 32'ha4000120;
  localparam logic [31:0] SECOND_DATA_IDX = 32'h04000122;
  localparam logic [31:0] FIRST_MODE_IDX = 32'h04000130;
  localparam logic [31:0] SECOND_MODE_IDX = 32'h04000131;
  // Index bits that decode; the upper three select a region only
  localparam int IDX_DECODE_BITS = 29;

  // -------------------------------------------------------------
  // Widths and reset values
  // -------------------------------------------------------------
  localparam int PORT_WIDTH = 8;
  localparam int MODE_WIDTH = 16;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // -------------------------------------------------------------
  // Pin mode field: bit 2n+1 is the high bit, bit 2n the low bit
  // -------------------------------------------------------------
  localparam int MODE_HI_OFS = 1;
  localparam int MODE_LO_OFS = 0;
  localparam logic [1:0] MODE_ALT = 2'b00;
  localparam logic [1:0] MODE_OUT = 2'b01;
  localparam logic [1:0] MODE_IN_PULL = 2'b10;
  localparam logic [1:0] MODE_IN_NOPULL = 2'b11;

  // Synchroniser depth on pin inputs
  localparam int SYNC_STAGES = 2;

  // Bus slave states
  typedef enum logic [0:0] {
    DBG_ST_IDLE = 1'b0,
    DBG_ST_ACK = 1'b1
  } dbg_bus_state_t;

endpackage : dbg_pkg

// *** hw/dbg_sync_if.sv ***
// Carrier between the port block and its pin synchroniser
`timescale 1ns/1ps
interface dbg_sync_if #(
  parameter int PINS = 16
);
  logic [PINS-1:0] raw;
  logic [PINS-1:0] synced;

  modport core (output raw, input synced);
  modport sync (input raw, output synced);
endinterface : dbg_sync_if

// *** hw/dbg_pin_sync.sv ***
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
module dbg_pin_sync #(
  parameter int PINS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  dbg_sync_if.sync sif
);

  // -------------------------------------------------------------
  // Per-pin stages
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : g_pin
      logic meta_reg;
      logic meta_next;
      logic stable_reg;
      logic stable_next;

      // First stage feeds only the second, never any logic
      always_comb begin
        meta_next = sif.raw[g];
        stable_next = meta_reg;
      end

      // Stages cleared on reset; pins are asynchronous to pclk
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg <= meta_next;
          stable_reg <= stable_next;
        end
      end

      assign sif.synced[g] = stable_reg;
    end
  endgenerate

endmodule : dbg_pin_sync

// *** dv/dbg_gpio_monitor.sv ***
// Concurrent checks on the APB and pin ports of the dual port data block
`timescale 1ns/1ps
module dbg_gpio_monitor #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [WIDTH-1:0] first_port_pin_in,
  input wire logic [WIDTH-1:0] first_port_pin_out,
  input wire logic [WIDTH-1:0] first_port_pin_oe,
  input wire logic [WIDTH-1:0] first_port_pullup_en,
  input wire logic [WIDTH-1:0] second_port_pin_in,
  input wire logic [WIDTH-1:0] second_port_pin_out,
  input wire logic [WIDTH-1:0] second_port_pin_oe,
  input wire logic [WIDTH-1:0] second_port_pullup_en
);
  // ------------------------------------------
  // Decode helpers
  // ------------------------------------------
  logic wr_done, rd_done, hit_a, hit_b, mapped;
  logic [WIDTH-1:0] wbyte, pin_last;
  logic [2:0] quiet;
  assign wr_done = psel && penable && pwrite && pready;
  assign rd_done = psel && penable && !pwrite && pready;
  assign hit_a = paddr[30:2] == dbg_pkg::FIRST_DATA_IDX[28:0];
  assign hit_b = paddr[30:2] == dbg_pkg::SECOND_DATA_IDX[28:0];
  assign mapped = hit_a || hit_b || paddr[30:2] == dbg_pkg::FIRST_MODE_IDX[28:0]
    || paddr[30:2] == dbg_pkg::SECOND_MODE_IDX[28:0];
  assign wbyte = pwdata[WIDTH-1:0];
  // Quiet count: the synchroniser lags, so only long-stable pins are compared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 3'h0;
      pin_last <= '0;
    end else begin
      quiet <= (second_port_pin_in != pin_last) ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
      pin_last <= second_port_pin_in;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("wrong answer cycle");
  property p_unmapped; psel && penable && pready && !mapped |-> pslverr && prdata == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access");
  property p_hold; !wr_done |=> $stable(first_port_pin_out) && $stable(second_port_pin_out); endproperty
  a_hold: assert property (p_hold) else $error("data changed without write");
  property p_wr_a; wr_done && hit_a && pstrb[0] |=> first_port_pin_out == $past(wbyte); endproperty
  a_wr_a: assert property (p_wr_a) else $error("first port write lost");
  property p_wr_b; wr_done && hit_b && pstrb[0] |=> second_port_pin_out == $past(wbyte); endproperty
  a_wr_b: assert property (p_wr_b) else $error("second port write lost");
  property p_rd_out; rd_done && hit_a |-> prdata[31:WIDTH] == '0
    && ((prdata[WIDTH-1:0] ^ first_port_pin_out) & first_port_pin_oe) == '0; endproperty
  a_rd_out: assert property (p_rd_out) else $error("output read wrong");
  property p_rd_in; rd_done && hit_b && quiet == 3'h7
    |-> ((prdata[WIDTH-1:0] ^ second_port_pin_in) & second_port_pullup_en) == '0; endproperty
  a_rd_in: assert property (p_rd_in) else $error("input read wrong");
endmodule : dbg_gpio_monitor

// *** dv/dbg_pin_board.sv ***
// Board-side model of one port's eight pins
`timescale 1ns/1ps
module dbg_pin_board (
  input wire logic clk,
  input wire logic [7:0] drv,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  // Undriven, unpulled pins wander every cycle
  logic [7:0] flt = 8'h00;
  always @(posedge clk) flt <= ~flt;
  // Device drive wins, then board drive, then pull-up, else floating
  assign level = (oe & drv) | (~oe & ext_en & ext_val)
    | (~oe & ~ext_en & pull) | (~oe & ~ext_en & ~pull & flt);
endmodule : dbg_pin_board

// *** dv/dbg_gpio_top_tb.sv ***
// Self-checking bench for the dual port data block
`timescale 1ns/1ps
module dbg_gpio_top_tb;
  localparam logic [31:0] A_DATA = dbg_pkg::FIRST_DATA_IDX << 2;
  localparam logic [31:0] A_ALIAS = dbg_pkg::FIRST_DATA_ALIAS_IDX << 2;
  localparam logic [31:0] B_DATA = dbg_pkg::SECOND_DATA_IDX << 2;
  localparam logic [31:0] A_MODE = dbg_pkg::FIRST_MODE_IDX << 2;
  localparam logic [31:0] B_MODE = dbg_pkg::SECOND_MODE_IDX << 2;
  localparam logic [31:0] NO_REG = A_DATA + 32'h4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, err;
  logic [7:0] a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu, ext_val = '0, ext_en = '0;
  int failures = 0, check_count = 0;
  always #5 pclk = ~pclk;
  dbg_gpio_top #(.WIDTH(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .first_port_pin_in(a_in),
    .first_port_pin_out(a_out), .first_port_pin_oe(a_oe), .first_port_pullup_en(a_pu),
    .second_port_pin_in(b_in), .second_port_pin_out(b_out), .second_port_pin_oe(b_oe),
    .second_port_pullup_en(b_pu));
  dbg_pin_board u_brd_a (.clk(pclk), .drv(a_out), .oe(a_oe), .pull(a_pu),
    .ext_val(ext_val), .ext_en(ext_en), .level(a_in));
  dbg_pin_board u_brd_b (.clk(pclk), .drv(b_out), .oe(b_oe), .pull(b_pu),
    .ext_val(ext_val), .ext_en(ext_en), .level(b_in));
  // ------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      failures++;
    end
  endtask : chk
  // One APB transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask : rd_chk
  // Board drive change, then time for the synchroniser
  task automatic board(input logic [7:0] en, input logic [7:0] v);
    @(posedge pclk);
    ext_en <= en;
    ext_val <= v;
    repeat (8) @(posedge pclk);
    #1;
  endtask : board
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_DATA, 32'h0);
    rd_chk(B_DATA, 32'h0);
    xfer(1'b1, A_MODE, 32'h5555, 4'h3);
    xfer(1'b1, A_DATA, 32'ha5, 4'h1);
    chk(32'(err), 32'h0);
    chk(32'({a_pu, a_oe, a_out}), 32'h00ffa5);
    rd_chk(A_DATA, 32'ha5);
    rd_chk(A_ALIAS, 32'ha5);
    rd_chk(A_MODE, 32'h5555);
    xfer(1'b1, A_DATA, 32'h5a, 4'he);
    rd_chk(A_DATA, 32'ha5);
    xfer(1'b1, NO_REG, 32'hff, 4'hf);
    chk(32'(err), 32'h1);
    rd_chk(NO_REG, 32'h0);
    rd_chk(A_DATA, 32'ha5);
    // Second port: input with pull-up alone, then board drive, then no pull-up, then alternate and output modes
    xfer(1'b1, B_MODE, 32'haaaa, 4'h3);
    xfer(1'b1, B_DATA, 32'h3c, 4'h1);
    board(8'h00, 8'h00);
    chk(32'({b_pu, b_oe}), 32'hff00);
    rd_chk(B_DATA, 32'hff);
    board(8'hff, 8'h96);
    rd_chk(B_DATA, 32'h96);
    xfer(1'b1, B_MODE, 32'hffff, 4'h3);
    board(8'hff, 8'h5a);
    chk(32'({b_pu, b_oe}), 32'h0);
    rd_chk(B_DATA, 32'h5a);
    xfer(1'b1, B_MODE, 32'h0, 4'h3);
    rd_chk(B_DATA, 32'h3c);
    xfer(1'b1, B_DATA, 32'h81, 4'h1);
    chk(32'(b_oe), 32'h0);
    xfer(1'b1, B_MODE, 32'h5555, 4'h3);
    board(8'h00, 8'h00);
    chk(32'({b_oe, b_out}), 32'hff81);
    rd_chk(B_DATA, 32'h81);
    // First port as input with pull-up: pins float high
    xfer(1'b1, A_MODE, 32'haaaa, 4'h3);
    board(8'h00, 8'h00);
    chk(32'({a_pu, a_oe}), 32'hff00);
    rd_chk(A_DATA, 32'hff);
    // Power-on reset in mid-run clears both registers
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'({a_out, b_out, a_oe, b_oe}), 32'h0);
    presetn <= 1'b1;
    rd_chk(A_DATA, 32'h0);
    rd_chk(B_DATA, 32'h0);
    give_verdict();
  end
endmodule : dbg_gpio_top_tb
bind dbg_gpio_top dbg_gpio_monitor #(.WIDTH(WIDTH)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .first_port_pin_in(first_port_pin_in), .first_port_pin_out(first_port_pin_out),
  .first_port_pin_oe(first_port_pin_oe), .first_port_pullup_en(first_port_pullup_en),
  .second_port_pin_in(second_port_pin_in), .second_port_pin_out(second_port_pin_out),
  .second_port_pin_oe(second_port_pin_oe), .second_port_pullup_en(second_port_pullup_en));
